// [rtl/tsm_pkg.sv]
// trigger state machine sampler: shared constants, encodings and carrier types
// assumes one 10 MHz clock domain; every width here is fixed at build time
package tsm_pkg;

   // ======================================================================
   // build-time shape
   localparam int N_STATES  = 4;
   localparam int STATE_W   = 2;
   localparam int TPS       = 2;                 // transitions per state, in priority order
   localparam int TIDX_W    = 1;
   localparam int N_TRANS   = N_STATES * TPS;
   localparam int TRANS_W   = STATE_W + TIDX_W;
   localparam int N_LOCAL   = 2;
   localparam int N_PEER    = 2;
   localparam int N_EXT     = 2;
   localparam int CNT_W     = 8;
   localparam bit CNT_EN    = 1'b1;              // counter built in
   localparam bit CROSS_EN  = 1'b1;              // peer-unit triggering built in
   localparam int DEPTH     = 2048;
   localparam int ADDR_W    = 11;
   localparam int FILL_W    = 12;
   localparam int SAMPLE_W  = 8;
   localparam int NSPT_W    = 8;                 // samples-per-trigger width

   // ======================================================================
   // condition term positions
   localparam int TERM_LOCAL = 0;
   localparam int TERM_ZERO  = TERM_LOCAL + N_LOCAL;
   localparam int TERM_PEER  = TERM_ZERO + 1;
   localparam int TERM_EXT   = TERM_PEER + N_PEER;
   localparam int N_TERMS    = TERM_EXT + N_EXT;
   localparam int LUT_W      = 1 << N_TERMS;

   // ======================================================================
   // reset values and fixed counts
   localparam logic [STATE_W-1:0] STATE_RESET = 2'h0;
   localparam logic [CNT_W-1:0]   CNT_RESET   = 8'h00;
   localparam logic [ADDR_W-1:0]  ADDR_RESET  = 11'h000;
   localparam logic [FILL_W-1:0]  FILL_FULL   = 12'h800;
   localparam logic [FILL_W-1:0]  FILL_RESET  = 12'h000;
   localparam logic [NSPT_W-1:0]  NSPT_ZERO   = 8'h00;
   localparam logic [NSPT_W-1:0]  NSPT_MIN    = 8'h01;

   // ======================================================================
   // sample modes
   localparam logic [1:0] MODE_NORMAL = 2'h0;   // circular until trigger
   localparam logic [1:0] MODE_FILL   = 2'h1;   // qualified, stop when full
   localparam logic [1:0] MODE_INTR   = 2'h2;   // qualified, circular until stop

   // ======================================================================
   // counter action of a transition: one field, so load and decrement exclude
   typedef enum logic [1:0] {
      CNT_NONE = 2'h0,
      CNT_DEC  = 2'h1,
      CNT_INC  = 2'h2,
      CNT_LOAD = 2'h3
   } tsm_cnt_op_t;

   // run control, one-hot
   typedef enum logic [3:0] {
      RUN_IDLE  = 4'h1,
      RUN_ARMED = 4'h2,
      RUN_STOP  = 4'h4,
      RUN_DRAIN = 4'h8
   } tsm_run_t;

   // one transition: condition truth table over the terms plus its actions
   typedef struct packed {
      logic [LUT_W-1:0]   cond_lut;
      logic               go_en;
      logic [STATE_W-1:0] go_state;
      tsm_cnt_op_t        cnt_op;
      logic [CNT_W-1:0]   load_val;
      logic               trig;
   } tsm_trans_t;

   typedef struct packed {
      logic [SAMPLE_W-1:0] data;
   } tsm_word_t;

endpackage

// [rtl/tsm_fifo2.sv]
// two-entry buffer with valid/ready on both sides
// assumes the caller holds in_data stable while in_valid waits for in_ready
`timescale 1ns/1ps
`default_nettype none
module tsm_fifo2
   import tsm_pkg::*;
(
   input  wire logic      clk,
   input  wire logic      rst_b,
   input  wire logic      in_valid,
   output logic           in_ready,
   input  wire tsm_word_t in_data,
   output logic           out_valid,
   input  wire logic      out_ready,
   output tsm_word_t      out_data
);

   // ======================================================================
   // storage
   tsm_word_t  slot_reg [2];
   logic       rd_sel_reg;
   logic       wr_sel_reg;
   logic [1:0] count_reg;
   logic       push;
   logic       pop;

   assign in_ready  = (count_reg != 2'h2);
   assign out_valid = (count_reg != 2'h0);
   assign out_data  = slot_reg[rd_sel_reg];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         slot_reg[wr_sel_reg] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rd_sel_reg <= 1'b0;
         wr_sel_reg <= 1'b0;
         count_reg  <= 2'h0;
      end else begin
         if (push) begin
            wr_sel_reg <= ~wr_sel_reg;
         end
         if (pop) begin
            rd_sel_reg <= ~rd_sel_reg;
         end
         count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
      end
   end

endmodule // tsm_fifo2
`default_nettype wire

// [rtl/tsm_store.sv]
// sample store: flip-flop array, one write port, combinational read by index
// assumes one write per cycle at most; no reset, contents are don't-care until written
`timescale 1ns/1ps
`default_nettype none
module tsm_store
   import tsm_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              wr_en,
   input  wire logic [ADDR_W-1:0] wr_addr,
   input  wire tsm_word_t         wr_data,
   input  wire logic [ADDR_W-1:0] rd_addr,
   output tsm_word_t              rd_data
);

   // ======================================================================
   // array
   tsm_word_t mem_reg [DEPTH];

   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem_reg[wr_addr] <= wr_data;
      end
   end

   assign rd_data = mem_reg[rd_addr];

endmodule // tsm_store
`default_nettype wire

// [rtl/tsm_top.sv]
// trigger state machine with counter, qualified sampling and buffer readout
// assumes configuration ports stay stable during a run; all inputs synchronous to clk
// Behaviour
// - decrement action lowers the counter by one; decrement and load exclude each other
// - load action sets the counter to the transition's load value
// - trigger action pulses the sample buffer trigger in the firing cycle
// - firing transition moves state to its target; no target keeps state
// - local trigger conditions of this unit are condition terms
// - counter-zero term true when counter is zero, only if counter built
// - peer unit triggers are condition terms when cross triggering built in
// - external trigger inputs are condition terms
// - conditions are any Boolean function of the terms
// - transitions of one state checked in order; first true one wins
// - state count, local condition count and counter width are build parameters
// - counter can count up, count down or load any value
// - sample depth is a build parameter held in on-chip storage
// - fill mode stores N samples per trigger and stops when full
// - stop mode overwrites circularly until the host stops
// - load on trigger plus decrement while nonzero gives periodic triggers
// - host software trigger ends data collection
// - each transition has one condition and up to three actions: state move, counter action and trigger
`timescale 1ns/1ps
`default_nettype none
module tsm_top
   import tsm_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                rst_b,
   input  wire logic                run_start,
   input  wire logic                host_stop,
   input  wire logic [1:0]          sample_mode,
   input  wire logic [NSPT_W-1:0]   samples_per_trig,
   input  wire tsm_trans_t          trans_cfg [N_TRANS],
   input  wire logic [N_LOCAL-1:0]  local_trigger_conditions,
   input  wire logic [N_PEER-1:0]   peer_unit_trigger,
   input  wire logic [N_EXT-1:0]    external_trigger_input,
   input  wire logic [SAMPLE_W-1:0] sample_data,
   output logic                     running,
   output logic                     collecting,
   output logic                     sample_trigger,
   output logic                     trig_seen,
   output logic                     buf_full,
   output logic [STATE_W-1:0]       trig_state,
   output logic [CNT_W-1:0]         trig_count,
   output logic                     rd_valid,
   input  wire logic                rd_ready,
   output logic [SAMPLE_W-1:0]      rd_data
);

   // ======================================================================
   // registers
   tsm_run_t             run_reg;
   tsm_run_t             run_next;
   logic [STATE_W-1:0]   state_reg;
   logic [CNT_W-1:0]     cnt_reg;
   logic                 trig_seen_reg;
   logic [ADDR_W-1:0]    wr_ptr_reg;
   logic [FILL_W-1:0]    fill_reg;
   logic [NSPT_W-1:0]    burst_reg;
   logic [ADDR_W-1:0]    rd_ptr_reg;
   logic [FILL_W-1:0]    rd_left_reg;

   // ======================================================================
   // condition terms
   logic [N_TERMS-1:0]   terms;
   logic [N_TRANS-1:0]   hit;
   logic                 armed;
   logic                 fire;
   logic [TRANS_W-1:0]   sel;
   tsm_trans_t           sel_cfg;

   always_comb begin
      terms                              = '0;
      terms[TERM_LOCAL +: N_LOCAL]       = local_trigger_conditions;
      terms[TERM_ZERO]                   = CNT_EN & (cnt_reg == CNT_RESET);
      terms[TERM_PEER +: N_PEER]         = CROSS_EN ? peer_unit_trigger : '0;
      terms[TERM_EXT +: N_EXT]           = external_trigger_input;
   end

   // each transition's condition is a full truth table over the terms
   generate
      for (genvar i = 0; i < N_TRANS; i++) begin : g_hit
         assign hit[i] = trans_cfg[i].cond_lut[terms];
      end
   endgenerate

   assign armed = (run_reg == RUN_ARMED);

   // scan from last to first so the earliest true transition wins
   always_comb begin
      fire = 1'b0;
      sel  = '0;
      for (int t = TPS - 1; t >= 0; t--) begin
         if (hit[{state_reg, TIDX_W'(t)}]) begin
            fire = armed;
            sel  = {state_reg, TIDX_W'(t)};
         end
      end
   end

   assign sel_cfg        = trans_cfg[sel];
   assign sample_trigger = fire & sel_cfg.trig;

   // ======================================================================
   // trigger state register
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state_reg <= STATE_RESET;
      end else if (run_start) begin
         state_reg <= STATE_RESET;
      end else if (fire && sel_cfg.go_en) begin
         state_reg <= sel_cfg.go_state;
      end
   end

   // ======================================================================
   // trigger counter; only a firing transition touches it
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         cnt_reg <= CNT_RESET;
      end else if (CNT_EN && fire) begin
         case (sel_cfg.cnt_op)
            CNT_DEC:  cnt_reg <= cnt_reg - 8'h01;
            CNT_INC:  cnt_reg <= cnt_reg + 8'h01;
            CNT_LOAD: cnt_reg <= sel_cfg.load_val;
            default:  cnt_reg <= cnt_reg;
         endcase
      end
   end

   // ======================================================================
   // run control
   logic qualified;
   logic wr_en;
   logic fill_done;

   assign qualified = (sample_mode == MODE_FILL) || (sample_mode == MODE_INTR);
   assign wr_en     = armed && (!qualified || sample_trigger || burst_reg != NSPT_ZERO);
   assign fill_done = (sample_mode == MODE_FILL) && wr_en
                      && (fill_reg == FILL_FULL - 12'h001);

   always_comb begin
      case (run_reg)
         RUN_IDLE: begin
            run_next = run_start ? RUN_ARMED : RUN_IDLE;
         end
         RUN_ARMED: begin
            if (run_start) begin
               run_next = RUN_ARMED;
            end else if (host_stop) begin
               run_next = RUN_STOP;
            end else if (fill_done) begin
               run_next = RUN_STOP;
            end else if (sample_mode == MODE_NORMAL && sample_trigger) begin
               run_next = RUN_STOP;
            end else begin
               run_next = RUN_ARMED;
            end
         end
         RUN_STOP: begin
            run_next = RUN_DRAIN;
         end
         RUN_DRAIN: begin
            if (run_start) begin
               run_next = RUN_ARMED;
            end else if (rd_left_reg == FILL_RESET) begin
               run_next = RUN_IDLE;
            end else begin
               run_next = RUN_DRAIN;
            end
         end
         default: begin
            run_next = RUN_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         run_reg <= RUN_IDLE;
      end else begin
         run_reg <= run_next;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         trig_seen_reg <= 1'b0;
      end else if (sample_trigger) begin
         trig_seen_reg <= 1'b1;
      end else if (run_start) begin
         trig_seen_reg <= 1'b0;
      end
   end

   // ======================================================================
   // sample writing
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         burst_reg <= NSPT_ZERO;
      end else if (run_start) begin
         burst_reg <= NSPT_ZERO;
      end else if (armed && qualified) begin
         if (sample_trigger) begin
            // the trigger cycle itself is the first sample of the burst
            burst_reg <= (samples_per_trig == NSPT_ZERO) ? NSPT_ZERO
                                                         : samples_per_trig - NSPT_MIN;
         end else if (burst_reg != NSPT_ZERO) begin
            burst_reg <= burst_reg - NSPT_MIN;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         wr_ptr_reg <= ADDR_RESET;
         fill_reg   <= FILL_RESET;
      end else if (run_start) begin
         wr_ptr_reg <= ADDR_RESET;
         fill_reg   <= FILL_RESET;
      end else if (wr_en) begin
         wr_ptr_reg <= wr_ptr_reg + 11'h001;
         if (fill_reg != FILL_FULL) begin
            fill_reg <= fill_reg + 12'h001;
         end
      end
   end

   // ======================================================================
   // readout, oldest sample first, through the two-entry buffer
   tsm_word_t wr_word;
   tsm_word_t mem_word;
   tsm_word_t out_word;
   logic      push_valid;
   logic      push_ready;

   assign wr_word.data = sample_data;
   assign push_valid   = (run_reg == RUN_DRAIN) && (rd_left_reg != FILL_RESET);

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rd_ptr_reg  <= ADDR_RESET;
         rd_left_reg <= FILL_RESET;
      end else if (run_reg == RUN_STOP) begin
         // a wrapped buffer starts at the write pointer, an unwrapped one at zero
         rd_ptr_reg  <= (fill_reg == FILL_FULL) ? wr_ptr_reg : ADDR_RESET;
         rd_left_reg <= fill_reg;
      end else if (run_start) begin
         rd_left_reg <= FILL_RESET;
      end else if (push_valid && push_ready) begin
         rd_ptr_reg  <= rd_ptr_reg + 11'h001;
         rd_left_reg <= rd_left_reg - 12'h001;
      end
   end

   tsm_store u_store (
      .clk     (clk),
      .wr_en   (wr_en),
      .wr_addr (wr_ptr_reg),
      .wr_data (wr_word),
      .rd_addr (rd_ptr_reg),
      .rd_data (mem_word)
   );

   tsm_fifo2 u_fifo (
      .clk       (clk),
      .rst_b     (rst_b),
      .in_valid  (push_valid),
      .in_ready  (push_ready),
      .in_data   (mem_word),
      .out_valid (rd_valid),
      .out_ready (rd_ready),
      .out_data  (out_word)
   );

   // ======================================================================
   // status
   assign rd_data    = out_word.data;
   assign running    = (run_reg != RUN_IDLE);
   assign collecting = armed;
   assign trig_seen  = trig_seen_reg;
   assign buf_full   = (fill_reg == FILL_FULL);
   assign trig_state = state_reg;
   assign trig_count = cnt_reg;

endmodule // tsm_top
`default_nettype wire

// [tb/tsm_top_monitor.sv]
// port checker for the trigger state machine sampler top
// assumes it is bound onto tsm_top; one clock, synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module tsm_top_monitor
   import tsm_pkg::*;
(
   input wire logic                clk,
   input wire logic                rst_b,
   input wire logic                run_start,
   input wire logic                host_stop,
   input wire logic [1:0]          sample_mode,
   input wire logic                running,
   input wire logic                collecting,
   input wire logic                sample_trigger,
   input wire logic                trig_seen,
   input wire logic                buf_full,
   input wire logic [STATE_W-1:0]  trig_state,
   input wire logic [CNT_W-1:0]    trig_count,
   input wire logic                rd_valid,
   input wire logic                rd_ready,
   input wire logic [SAMPLE_W-1:0] rd_data
);
   // =====================================================================
   // assertions
   AST_RESET_CLEAR: assert property (@(posedge clk) disable iff (1'b0)
      !rst_b |=> !running && !trig_seen && !buf_full && !rd_valid
      && trig_state == STATE_RESET && trig_count == CNT_RESET)
      else $error("outputs not cleared by reset");
   AST_TRIG_ARMED: assert property (@(posedge clk) disable iff (!rst_b)
      sample_trigger |-> collecting && running) else $error("trigger outside collection");
   AST_TRIG_STICKY: assert property (@(posedge clk) disable iff (!rst_b)
      sample_trigger |=> trig_seen) else $error("trigger not remembered");
   AST_RUN_ARM: assert property (@(posedge clk) disable iff (!rst_b)
      run_start && !collecting |=> collecting && trig_state == STATE_RESET
      && !trig_seen && !buf_full) else $error("run start did not arm cleanly");
   AST_STOP_ENDS: assert property (@(posedge clk) disable iff (!rst_b)
      collecting && host_stop && !run_start |=> !collecting && running)
      else $error("host stop did not end collection");
   AST_IDLE_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
      !collecting && !run_start |=> $stable(trig_state) && $stable(trig_count))
      else $error("state or counter moved while not armed");
   AST_FULL_STOPS: assert property (@(posedge clk) disable iff (!rst_b)
      buf_full && sample_mode == MODE_FILL |-> !collecting)
      else $error("still collecting with full buffer");
   AST_READ_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
      rd_valid && !rd_ready && !run_start |=> rd_valid && $stable(rd_data))
      else $error("readout word dropped during stall");
   COV_TRIGGER: cover property (@(posedge clk) sample_trigger);
   COV_FULL: cover property (@(posedge clk) buf_full);
   COV_STALL: cover property (@(posedge clk) rd_valid && !rd_ready);
endmodule // tsm_top_monitor

bind tsm_top tsm_top_monitor u_tsm_top_monitor (
   .clk(clk), .rst_b(rst_b), .run_start(run_start), .host_stop(host_stop),
   .sample_mode(sample_mode),
   .running(running), .collecting(collecting), .sample_trigger(sample_trigger),
   .trig_seen(trig_seen), .buf_full(buf_full), .trig_state(trig_state),
   .trig_count(trig_count), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data)
);
`default_nettype wire

// [tb/tsm_host_model.sv]
// host-side readout consumer: takes drained sample words into a queue
// assumes rd_valid/rd_data follow the valid-ready rules of the readout port
`timescale 1ns/1ps
`default_nettype none
module tsm_host_model
   import tsm_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                rst_b,
   input  wire logic                stall_en,
   input  wire logic                rd_valid,
   output logic                     rd_ready,
   input  wire logic [SAMPLE_W-1:0] rd_data
);
   logic [SAMPLE_W-1:0] got [$];
   logic [1:0]          pace_reg;
   // =====================================================================
   // consumer
   // refusing two cycles in four backs the two-entry buffer up on purpose
   always @(posedge clk) begin
      if (!rst_b) begin
         rd_ready <= 1'b0;
         pace_reg <= 2'h0;
      end else begin
         pace_reg <= pace_reg + 2'h1;
         rd_ready <= !stall_en || pace_reg[1];
         if (rd_valid && rd_ready) begin
            got.push_back(rd_data);
         end
      end
   end
endmodule // tsm_host_model
`default_nettype wire

// [tb/tsm_top_test.sv]
// self-checking bench for the trigger state machine sampler
// assumes tsm_top, the bound checker and the host readout model are compiled first
`timescale 1ns/1ps
`default_nettype none
module tsm_top_test
   import tsm_pkg::*;
;
   logic                clk, rst_b, run_start, host_stop, stall_en;
   logic [1:0]          sample_mode;
   logic [NSPT_W-1:0]   samples_per_trig;
   tsm_trans_t          trans_cfg [N_TRANS];
   logic [N_LOCAL-1:0]  loc_in;
   logic [N_PEER-1:0]   peer_in;
   logic [N_EXT-1:0]    ext_in;
   logic [SAMPLE_W-1:0] sample_data, rd_data;
   logic                running, collecting, sample_trigger, trig_seen, buf_full;
   logic                rd_valid, rd_ready;
   logic [STATE_W-1:0]  trig_state;
   logic [CNT_W-1:0]    trig_count;
   logic [SAMPLE_W-1:0] exp_q [$];
   int                  errors, total_checks;

   tsm_top u_tsm_top (.clk(clk), .rst_b(rst_b), .run_start(run_start),
      .host_stop(host_stop), .sample_mode(sample_mode), .samples_per_trig(samples_per_trig),
      .trans_cfg(trans_cfg), .local_trigger_conditions(loc_in), .peer_unit_trigger(peer_in),
      .external_trigger_input(ext_in), .sample_data(sample_data), .running(running),
      .collecting(collecting), .sample_trigger(sample_trigger), .trig_seen(trig_seen),
      .buf_full(buf_full), .trig_state(trig_state), .trig_count(trig_count),
      .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data));
   tsm_host_model u_tsm_host_model (.clk(clk), .rst_b(rst_b), .stall_en(stall_en),
      .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data));

   always #50 clk = ~clk;
   always @(posedge clk) sample_data <= sample_data + 8'h01;

   // =====================================================================
   // shared tasks
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // one cycle of stimulus; returns once the edge's updates have landed
   task automatic drive(input logic [1:0] l, input logic [1:0] p, input logic [1:0] e,
                        input logic rs, input logic hs);
      @(posedge clk);
      loc_in <= l;
      peer_in <= p;
      ext_in <= e;
      run_start <= rs;
      host_stop <= hs;
      #1;
   endtask

   // term vector: local 0..1, counter zero 2, peer 3..4, external 5..6
   function automatic logic [LUT_W-1:0] mk_lut(input logic [N_TERMS-1:0] m,
                                               input logic [N_TERMS-1:0] v);
      logic [LUT_W-1:0] l;
      for (int i = 0; i < LUT_W; i++) l[i] = ((N_TERMS'(i) & m) == v);
      return l;
   endfunction

   task automatic set_trans(input int idx, input logic [LUT_W-1:0] lut, input logic go,
      input logic [STATE_W-1:0] tgt, input tsm_cnt_op_t op, input logic [CNT_W-1:0] ld,
      input logic trg);
      @(posedge clk);
      trans_cfg[idx] <= '{lut, go, tgt, op, ld, trg};
   endtask

   task automatic setup(input logic [1:0] mode, input logic [NSPT_W-1:0] n, input logic st);
      @(posedge clk);
      foreach (trans_cfg[i]) trans_cfg[i] <= '0;
      sample_mode <= mode;
      samples_per_trig <= n;
      stall_en <= st;
      exp_q.delete();
      u_tsm_host_model.got.delete();
   endtask

   task automatic drain_and_compare(input int limit);
      int n;
      n = 0;
      while (running === 1'b1 || rd_valid === 1'b1) begin
         @(posedge clk);
         #1;
         n++;
         if (n > limit) begin
            errors++;
            $display("unexpected wait for readout end: expected idle seen busy");
            tally_and_finish;
         end
      end
      check("word count", u_tsm_host_model.got.size(), exp_q.size());
      foreach (exp_q[i]) check("word", u_tsm_host_model.got[i], exp_q[i]);
   endtask

   // =====================================================================
   // scenarios
   task automatic test_reset;
      check("running", running, 1'b0);
      check("collecting", collecting, 1'b0);
      check("trig_seen", trig_seen, 1'b0);
      check("buf_full", buf_full, 1'b0);
      check("trig_state", trig_state, 2'h0);
      check("trig_count", trig_count, 8'h00);
      $display("test reset done");
   endtask

   task automatic test_sequence;
      logic [SAMPLE_W-1:0] base;
      setup(MODE_INTR, 8'h03, 1'b0);
      set_trans(0, mk_lut(7'h01, 7'h01), 1'b1, 2'h1, CNT_LOAD, 8'h0F, 1'b1);
      set_trans(1, '1, 1'b1, 2'h2, CNT_NONE, 8'h00, 1'b0);
      set_trans(2, mk_lut(7'h0C, 7'h08), 1'b0, 2'h0, CNT_DEC, 8'h00, 1'b0);
      set_trans(3, mk_lut(7'h44, 7'h44), 1'b1, 2'h3, CNT_NONE, 8'h00, 1'b1);
      set_trans(6, mk_lut(7'h02, 7'h02), 1'b0, 2'h0, CNT_INC, 8'h00, 1'b0);
      drive(2'h0, 2'h0, 2'h0, 1'b1, 1'b0);
      drive(2'h1, 2'h0, 2'h0, 1'b0, 1'b0);
      check("collecting", collecting, 1'b1);
      check("trigger on first of two", sample_trigger, 1'b1);
      base = sample_data;
      for (int i = 0; i < 3; i++) exp_q.push_back(SAMPLE_W'(base + i));
      drive(2'h0, 2'h1, 2'h0, 1'b0, 1'b0);
      check("state after load", trig_state, 2'h1);
      check("loaded count", trig_count, 8'h0F);
      repeat (15) drive(2'h0, 2'h1, 2'h0, 1'b0, 1'b0);
      check("count after 15 decrements", trig_count, 8'h00);
      drive(2'h0, 2'h1, 2'h0, 1'b0, 1'b0);
      check("count held at zero", trig_count, 8'h00);
      check("no trigger without external", sample_trigger, 1'b0);
      drive(2'h0, 2'h0, 2'h2, 1'b0, 1'b0);
      check("zero and external trigger", sample_trigger, 1'b1);
      base = sample_data;
      for (int i = 0; i < 3; i++) exp_q.push_back(SAMPLE_W'(base + i));
      drive(2'h2, 2'h0, 2'h0, 1'b0, 1'b0);
      check("state after second trigger", trig_state, 2'h3);
      drive(2'h2, 2'h0, 2'h0, 1'b0, 1'b0);
      drive(2'h0, 2'h0, 2'h0, 1'b0, 1'b0);
      check("count after increments", trig_count, 8'h02);
      drive(2'h0, 2'h0, 2'h0, 1'b0, 1'b0);
      check("idle count held", trig_count, 8'h02);
      check("state without target held", trig_state, 2'h3);
      drive(2'h0, 2'h0, 2'h0, 1'b0, 1'b1);
      drive(2'h0, 2'h0, 2'h0, 1'b0, 1'b0);
      check("collecting after stop", collecting, 1'b0);
      check("running after stop", running, 1'b1);
      drain_and_compare(200);
      $display("test sequence done");
   endtask

   task automatic test_fill;
      logic [SAMPLE_W-1:0] base;
      int                  n;
      setup(MODE_FILL, 8'h01, 1'b1);
      set_trans(0, '1, 1'b0, 2'h0, CNT_NONE, 8'h00, 1'b1);
      drive(2'h0, 2'h0, 2'h0, 1'b1, 1'b0);
      drive(2'h0, 2'h0, 2'h0, 1'b0, 1'b0);
      base = sample_data;
      n = 0;
      while (buf_full !== 1'b1 && n < 2100) begin
         drive(2'h0, 2'h0, 2'h0, 1'b0, 1'b0);
         n++;
      end
      check("cycles to full", n, 32'h800);
      check("collecting when full", collecting, 1'b0);
      for (int i = 0; i < DEPTH; i++) exp_q.push_back(SAMPLE_W'(base + i));
      drain_and_compare(9000);
      $display("test fill done");
   endtask

   task automatic test_normal;
      logic [SAMPLE_W-1:0] base;
      setup(MODE_NORMAL, 8'h01, 1'b0);
      set_trans(0, mk_lut(7'h01, 7'h01), 1'b0, 2'h0, CNT_NONE, 8'h00, 1'b1);
      drive(2'h0, 2'h0, 2'h0, 1'b1, 1'b0);
      drive(2'h0, 2'h0, 2'h0, 1'b0, 1'b0);
      base = sample_data;
      repeat (3) drive(2'h0, 2'h0, 2'h0, 1'b0, 1'b0);
      drive(2'h1, 2'h0, 2'h0, 1'b0, 1'b0);
      check("normal trigger", sample_trigger, 1'b1);
      for (int i = 0; i < 5; i++) exp_q.push_back(SAMPLE_W'(base + i));
      drive(2'h0, 2'h0, 2'h0, 1'b0, 1'b0);
      check("normal stop", collecting, 1'b0);
      drain_and_compare(200);
      $display("test normal done");
   endtask

   // =====================================================================
   // main sequence
   initial begin
      clk = 1'b0;
      rst_b = 1'b0;
      run_start = 1'b0;
      host_stop = 1'b0;
      stall_en = 1'b0;
      sample_mode = MODE_NORMAL;
      samples_per_trig = NSPT_MIN;
      loc_in = 2'h0;
      peer_in = 2'h0;
      ext_in = 2'h0;
      sample_data = 8'h00;
      foreach (trans_cfg[i]) trans_cfg[i] = '0;
      errors = 0;
      total_checks = 0;
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      #1;
      test_reset;
      test_sequence;
      test_fill;
      test_normal;
      tally_and_finish;
   end
endmodule // tsm_top_test
`default_nettype wire
